// *** perf_fe_cfg.svh ***
// Offsets, field positions, encodings and timing counts of the counter
`ifndef PERF_FE_CFG_SVH
`define PERF_FE_CFG_SVH

// Register byte offsets
`define REG_CTRL_OFS          12'h000
`define REG_COUNT_OFS         12'h004
`define REG_STATUS_OFS        12'h008

// Control register fields
`define CTRL_EVT_LSB          0
`define CTRL_MASK_LSB         8
`define CTRL_EN_BIT           16
`define CTRL_RESET            32'h0000_0000

// Event codes
`define EVT_MOD_HIT_DRV       8'h7B
`define EVT_QUEUE_IDLE        8'h7D
`define EVT_SNOOP_STALL       8'h7E
`define EVT_IO_WAIT           8'h7F
`define EVT_FETCH             8'h80
`define EVT_FETCH_MISS        8'h81
`define EVT_XLATE             8'h82
`define EVT_IQ                8'h83
`define EVT_FETCH_STALL       8'h86
`define EVT_SLOW_DECODE       8'h87

// Unit masks
`define MASK_NONE             8'h00
`define MASK_SMALL_MISS       8'h02
`define MASK_LARGE_MISS       8'h10
`define MASK_XLATE_FLUSH      8'h40
`define MASK_ANY_MISS         8'h12
`define MASK_IQ_FULL          8'h02

// Core qualifier field of the unit mask
`define CORE_FIELD_MSB        7
`define CORE_FIELD_LSB        6
`define CORE_PER_CORE_QUALIFIER             2'h1
`define CORE_BOTH             2'h3

// Timing counts
`define SNOOP_RESP_LIMIT      3
`define SNOOP_STALL_LEN       2
`define SLOW_DECODE_CYCLES    3'h6

// Bus responses
`define AXI_OKAY              2'h0
`define AXI_SLVERR            2'h2

`endif

// *** perf_fe_pkg.sv ***
// Types shared by the front-end and bus event counter
package perf_fe_pkg;

  // Condition strobes from front-end and bus interface
  typedef struct packed {
    logic bus_cycle;           // One core cycle per bus cycle
    logic mod_hit_drive;       // Drives modified_hit_response_pin
    logic queue_empty_per_core_qualifier;
    logic queue_empty_other;
    logic halted_per_core_qualifier;
    logic halted_other;
    logic snoop_stall_bus;     // Stall driven by another agent
    logic snoop_req;           // Snoop request needing our answer
    logic snoop_resp;          // Our snoop answer is ready
    logic io_wait_per_core_qualifier;
    logic io_wait_other;
    logic fetch;               // Cached fetch through the fetch unit
    logic uc_fetch;            // Uncacheable fetch bypassing it
    logic fetch_miss_pend;     // Level while a fetch miss is outstanding
    logic small_page_miss;
    logic large_page_miss;
    logic xlate_flush;
    logic iq_full;
    logic stall_cache_miss;
    logic stall_xlate_miss;
    logic stall_xlate_fault;
    logic slow_decode_start;   // Instruction needs the slow decoder
  } fe_events_t;

  // Front-end controls driven back by the block
  typedef struct packed {
    logic snoop_stall_drive;
    logic snoop_start_allow;
    logic fetch_hold;
    logic slow_decode_busy;
  } fe_ctl_t;

  typedef enum logic [1:0] {
    SNP_IDLE,
    SNP_WAIT,
    SNP_STALL
  } snoop_state_t;

endpackage

// *** snoop_stall_gen.sv ***
// Snoop stall generator for late snoop answers
`timescale 1ns/1ns
`include "perf_fe_cfg.svh"
module snoop_stall_gen #(
  parameter int RESP_LIMIT = `SNOOP_RESP_LIMIT,
  parameter int STALL_LEN  = `SNOOP_STALL_LEN
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic bus_cycle,
  input  wire logic snoop_req,
  input  wire logic snoop_resp,
  output logic      stall
);

  perf_fe_pkg::snoop_state_t state_r;
  logic [3:0]                cnt_r;
  logic                      resp_seen_r;

  // Answer may land during a stall, remembered until it ends
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      resp_seen_r <= 1'b0;
    end else if (state_r != perf_fe_pkg::SNP_STALL) begin
      resp_seen_r <= 1'b0;
    end else if (snoop_resp) begin
      resp_seen_r <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= perf_fe_pkg::SNP_IDLE;
      cnt_r   <= 4'h0;
    end else begin
      case (state_r)
        perf_fe_pkg::SNP_IDLE: begin
          cnt_r <= 4'h0;
          if (snoop_req && !snoop_resp) begin
            state_r <= perf_fe_pkg::SNP_WAIT;
          end
        end
        perf_fe_pkg::SNP_WAIT: begin
          if (snoop_resp) begin
            state_r <= perf_fe_pkg::SNP_IDLE;
          end else if (bus_cycle) begin
            if (cnt_r == 4'(RESP_LIMIT - 1)) begin
              state_r <= perf_fe_pkg::SNP_STALL;
              cnt_r   <= 4'h0;
            end else begin
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        perf_fe_pkg::SNP_STALL: begin
          if (bus_cycle) begin
            if (cnt_r == 4'(STALL_LEN - 1)) begin
              cnt_r   <= 4'h0;
              state_r <= (resp_seen_r || snoop_resp) ?
                         perf_fe_pkg::SNP_IDLE : perf_fe_pkg::SNP_WAIT;
            end else begin
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        default: begin
          state_r <= perf_fe_pkg::SNP_IDLE;
        end
      endcase
    end
  end

  assign stall = (state_r == perf_fe_pkg::SNP_STALL);

endmodule

// *** perf_fe_counter.sv ***
// Front-end and bus event counter with AXI4-Lite registers
`timescale 1ns/1ns
`include "perf_fe_cfg.svh"
module perf_fe_counter #(
  parameter int COUNT_W = 32,
  parameter int ADDR_W  = 12
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [ADDR_W-1:0]       s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire perf_fe_pkg::fe_events_t ev,
  output perf_fe_pkg::fe_ctl_t         ctl
);

  // Bus slave state
  logic [ADDR_W-1:0] aw_addr_r;
  logic              aw_held_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              w_held_r;
  logic              do_write;
  logic              hit_ctrl;
  logic              hit_count;
  logic              hit_status;

  // Programmable and counting state
  logic [31:0]        ctrl_r;
  logic [COUNT_W-1:0] count_r;
  logic [COUNT_W-1:0] count_nxt;
  logic [7:0]         evt_code;
  logic [7:0]         evt_mask;
  logic [1:0]         core_sel;
  logic               count_en;
  logic               match;
  logic [1:0]         inc;

  // Event conditioning
  logic       stall_own;
  logic       stall_bus;
  logic       stall_prev_r;
  logic       stall_rise;
  logic       miss_prev_r;
  logic       miss_new;
  logic [2:0] slow_cnt_r;
  logic       slow_busy;
  logic       idle_per_core_qualifier;
  logic       idle_other;

  // Byte-lane merge for writable registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // Address and data are accepted in either order
  assign s_axi_awready = !aw_held_r;
  assign s_axi_wready  = !w_held_r;
  assign do_write      = aw_held_r && w_held_r && !s_axi_bvalid;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held_r <= 1'b0;
      aw_addr_r <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      aw_addr_r <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held_r <= 1'b0;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      w_data_r <= s_axi_wdata;
      w_strb_r <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_r <= 1'b0;
    end
  end

  // Write decode, status is read only
  always_comb begin
    hit_ctrl  = 1'b0;
    hit_count = 1'b0;
    if (aw_addr_r == ADDR_W'(`REG_CTRL_OFS)) begin
      hit_ctrl = 1'b1;
    end else if (aw_addr_r == ADDR_W'(`REG_COUNT_OFS)) begin
      hit_count = 1'b1;
    end
  end

  // Write response, status and unmapped give an error
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (hit_ctrl || hit_count) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Control register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r <= `CTRL_RESET;
    end else if (do_write && hit_ctrl) begin
      ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r);
    end
  end

  assign evt_code = ctrl_r[`CTRL_EVT_LSB +: 8];
  assign evt_mask = ctrl_r[`CTRL_MASK_LSB +: 8];
  assign core_sel = evt_mask[`CORE_FIELD_MSB:`CORE_FIELD_LSB];
  assign count_en = ctrl_r[`CTRL_EN_BIT];

  // Read channel, one read under way at a time
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    hit_status = (s_axi_araddr == ADDR_W'(`REG_STATUS_OFS));
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_OKAY;
      if (s_axi_araddr == ADDR_W'(`REG_CTRL_OFS)) begin
        s_axi_rdata <= ctrl_r;
      end else if (s_axi_araddr == ADDR_W'(`REG_COUNT_OFS)) begin
        s_axi_rdata <= 32'(count_r);
      end else if (hit_status) begin
        s_axi_rdata <= {28'h000_0000, slow_busy, ctl.fetch_hold,
                        stall_bus, match};
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= `AXI_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  snoop_stall_gen #(
    .RESP_LIMIT (`SNOOP_RESP_LIMIT),
    .STALL_LEN  (`SNOOP_STALL_LEN)
  ) u_snoop_stall (
    .clk        (clk),
    .reset_n    (reset_n),
    .bus_cycle  (ev.bus_cycle),
    .snoop_req  (ev.snoop_req),
    .snoop_resp (ev.snoop_resp),
    .stall      (stall_own)
  );

  assign stall_bus = stall_own || ev.snoop_stall_bus;

  // Bus signals are sampled once per bus cycle only
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stall_prev_r <= 1'b0;
    end else if (ev.bus_cycle) begin
      stall_prev_r <= stall_bus;
    end
  end

  assign stall_rise = ev.bus_cycle && stall_bus && !stall_prev_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      miss_prev_r <= 1'b0;
    end else begin
      miss_prev_r <= ev.fetch_miss_pend;
    end
  end

  assign miss_new = ev.fetch_miss_pend && !miss_prev_r;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_cnt_r <= 3'h0;
    end else if (slow_cnt_r != 3'h0) begin
      slow_cnt_r <= slow_cnt_r - 3'h1;
    end else if (ev.slow_decode_start) begin
      slow_cnt_r <= `SLOW_DECODE_CYCLES;
    end
  end

  assign slow_busy = (slow_cnt_r != 3'h0);

  assign idle_per_core_qualifier  = ev.queue_empty_per_core_qualifier ||
                      (ev.halted_per_core_qualifier && !ev.halted_other);
  assign idle_other = ev.queue_empty_other ||
                      (ev.halted_other && !ev.halted_per_core_qualifier);

  // Event select; a miss pair may add two in one cycle
  always_comb begin
    match = 1'b0;
    inc   = 2'h0;
    case (evt_code)
      `EVT_MOD_HIT_DRV: begin
        match = 1'b1;
        inc   = {1'b0, ev.bus_cycle && ev.mod_hit_drive};
      end
      `EVT_QUEUE_IDLE: begin
        if (core_sel == `CORE_PER_CORE_QUALIFIER) begin
          match = 1'b1;
          inc   = {1'b0, idle_per_core_qualifier};
        end else if (core_sel == `CORE_BOTH) begin
          match = 1'b1;
          inc   = {1'b0, idle_per_core_qualifier && idle_other};
        end
      end
      `EVT_SNOOP_STALL: begin
        match = 1'b1;
        inc   = {1'b0, stall_rise};
      end
      `EVT_IO_WAIT: begin
        if (core_sel == `CORE_PER_CORE_QUALIFIER) begin
          match = 1'b1;
          inc   = {1'b0, ev.io_wait_per_core_qualifier};
        end else if (core_sel == `CORE_BOTH) begin
          match = 1'b1;
          inc   = {1'b0, ev.io_wait_per_core_qualifier || ev.io_wait_other};
        end
      end
      `EVT_FETCH: begin
        if (evt_mask == `MASK_NONE) begin
          match = 1'b1;
          inc   = {1'b0, ev.fetch} + {1'b0, ev.uc_fetch};
        end
      end
      `EVT_FETCH_MISS: begin
        if (evt_mask == `MASK_NONE) begin
          match = 1'b1;
          inc   = {1'b0, miss_new} + {1'b0, ev.uc_fetch};
        end
      end
      `EVT_XLATE: begin
        if (evt_mask == `MASK_SMALL_MISS) begin
          match = 1'b1;
          inc   = {1'b0, ev.small_page_miss};
        end else if (evt_mask == `MASK_LARGE_MISS) begin
          match = 1'b1;
          inc   = {1'b0, ev.large_page_miss};
        end else if (evt_mask == `MASK_XLATE_FLUSH) begin
          match = 1'b1;
          inc   = {1'b0, ev.xlate_flush};
        end else if (evt_mask == `MASK_ANY_MISS) begin
          match = 1'b1;
          inc   = {1'b0, ev.small_page_miss} + {1'b0, ev.large_page_miss};
        end
      end
      `EVT_IQ: begin
        if (evt_mask == `MASK_IQ_FULL) begin
          match = 1'b1;
          inc   = {1'b0, ev.iq_full};
        end
      end
      `EVT_FETCH_STALL: begin
        if (evt_mask == `MASK_NONE) begin
          match = 1'b1;
          inc   = {1'b0, ev.stall_cache_miss || ev.stall_xlate_miss ||
                         ev.stall_xlate_fault};
        end
      end
      `EVT_SLOW_DECODE: begin
        if (evt_mask == `MASK_NONE) begin
          match = 1'b1;
          inc   = {1'b0, slow_busy};
        end
      end
      default: begin
        match = 1'b0;
        inc   = 2'h0;
      end
    endcase
  end

  always_comb begin
    count_nxt = count_r;
    if (count_en && match) begin
      count_nxt = count_r + COUNT_W'(inc);
    end
  end

  // Software load wins over a same-cycle event
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
    end else if (do_write && hit_count) begin
      count_r <= COUNT_W'(merge(32'(count_r), w_data_r, w_strb_r));
    end else begin
      count_r <= count_nxt;
    end
  end

  assign ctl.fetch_hold        = ev.iq_full;
  assign ctl.snoop_start_allow = !stall_bus;
  assign ctl.snoop_stall_drive = stall_own;
  assign ctl.slow_decode_busy  = slow_busy;

endmodule

// *** perf_fe_counter_sva.sv ***
// Port checker for the front-end and bus event counter
`timescale 1ns/1ns
module perf_fe_counter_sva (
  input wire logic                    clk,
  input wire logic                    reset_n,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  input wire perf_fe_pkg::fe_events_t ev,
  input wire perf_fe_pkg::fe_ctl_t    ctl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Fetch stops in the same cycle the queue fills
  property p_hold_iq;
    ctl.fetch_hold == ev.iq_full;
  endproperty
  a_hold_iq: assert property (p_hold_iq)
    else $error("fetch hold does not follow queue full");

  // No snoop start while any stall is up
  property p_no_start;
    ctl.snoop_start_allow == !(ctl.snoop_stall_drive | ev.snoop_stall_bus);
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("snoop start allowed during stall");

  // Own stall only begins on a bus cycle
  property p_stall_on_bus;
    $rose(ctl.snoop_stall_drive) |-> $past(ev.bus_cycle);
  endproperty
  a_stall_on_bus: assert property (p_stall_on_bus)
    else $error("stall rose outside a bus cycle");

  // Slow decode starts the cycle after its request
  property p_slow_start;
    ev.slow_decode_start && !ctl.slow_decode_busy |=> ctl.slow_decode_busy;
  endproperty
  a_slow_start: assert property (p_slow_start)
    else $error("slow decode did not start");

  // Six busy cycles per slow instruction, no more
  property p_slow_len;
    $rose(ctl.slow_decode_busy) |->
      ctl.slow_decode_busy [*6] ##1 !ctl.slow_decode_busy;
  endproperty
  a_slow_len: assert property (p_slow_len)
    else $error("slow decode length wrong");

  // Busy never rises without a start request
  property p_busy_cause;
    $rose(ctl.slow_decode_busy) |-> $past(ev.slow_decode_start);
  endproperty
  a_busy_cause: assert property (p_busy_cause)
    else $error("slow decode busy without start");

  // Read answer one cycle after the address is taken
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer)
    else $error("read answer late");

  // Second read refused while data is pending
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block)
    else $error("read address taken while data pending");
endmodule

bind perf_fe_counter perf_fe_counter_sva u_sva (
  .clk(clk), .reset_n(reset_n), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .ev(ev), .ctl(ctl)
);

// *** fe_partner.sv ***
// Front-end and bus model that feeds the counter's event strobes
`timescale 1ns/1ns
module fe_partner (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  input  wire perf_fe_pkg::fe_events_t drive,
  input  wire logic [3:0]              resp_dly,
  input  wire perf_fe_pkg::fe_ctl_t    ctl,
  output perf_fe_pkg::fe_events_t      ev
);
  logic [1:0] div_r;
  logic [3:0] wait_r;
  logic       pend_r;
  logic       bus_c;
  logic       req_c;

  // Bus runs at a quarter of the core clock
  assign bus_c = (div_r == 2'h3);
  assign req_c = drive.snoop_req & ctl.snoop_start_allow & !pend_r;

  // Bus cycle divider
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) div_r <= 2'h0;
    else div_r <= div_r + 2'h1;
  end

  // A long answer delay is what forces the counter to stall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_r <= 1'b0;
      wait_r <= 4'h0;
    end else if (req_c) begin
      pend_r <= 1'b1;
      wait_r <= resp_dly;
    end else if (pend_r && bus_c) begin
      if (wait_r == 4'h0) pend_r <= 1'b0;
      else wait_r <= wait_r - 4'h1;
    end
  end

  // Strobes pass through; bus pulse, gated snoop request and snoop answer made here
  always_comb begin
    ev            = drive;
    ev.bus_cycle  = bus_c;
    ev.snoop_req  = req_c;
    ev.snoop_resp = pend_r & bus_c & (wait_r == 4'h0);
  end
endmodule

// *** perf_event_bus_frontend_counter_tb.sv ***
// Per_core_qualifier-checking bench for the front-end and bus event counter
`timescale 1ns/1ns
`define CHK(got, exp) \
  begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp); \
    end \
  end
module perf_event_bus_frontend_counter_tb;
  logic        clk, reset_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  s_axi_wstrb, resp_dly;
  int          num_errors = 0;
  int          checks_done = 0;
  perf_fe_pkg::fe_events_t drive, ev;
  perf_fe_pkg::fe_ctl_t    ctl;

  perf_fe_counter u_dut (
    .clk(clk), .reset_n(reset_n), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ev(ev), .ctl(ctl)
  );
  fe_partner u_partner (
    .clk(clk), .reset_n(reset_n), .drive(drive), .resp_dly(resp_dly),
    .ctl(ctl), .ev(ev)
  );

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // One bus access; rsp holds response code and read data
  task automatic axi(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [33:0] rsp);
    logic ok, aw, w, ar;
    ok = 1'b0;
    rsp = {2'h3, 32'h0};
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= wd;
    s_axi_awvalid <= wr;
    s_axi_wvalid <= wr;
    s_axi_bready <= wr;
    s_axi_arvalid <= !wr;
    s_axi_rready <= !wr;
    // Sample mid-cycle, release right after the taking edge
    while (!ok) begin
      @(negedge clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      ar = s_axi_arvalid & s_axi_arready;
      ok = wr ? s_axi_bvalid : s_axi_rvalid;
      if (ok) rsp = wr ? {s_axi_bresp, 32'h0} : {s_axi_rresp, s_axi_rdata};
      @(posedge clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask

  // Program code and mask, drive n cycles, read the count back
  task automatic run(input logic [15:0] cm, input perf_fe_pkg::fe_events_t d,
                     input int n, input int exp);
    logic [33:0] rsp;
    axi(1'b1, 12'h000, {15'h0, 1'b1, cm[7:0], cm[15:8]}, rsp);
    axi(1'b1, 12'h004, 32'h0, rsp);
    @(posedge clk);
    drive <= d;
    repeat (n) @(posedge clk);
    drive <= '0;
    repeat (40) @(posedge clk);
    axi(1'b0, 12'h004, 32'h0, rsp);
    `CHK(rsp, {2'h0, 32'(exp)})
  endtask

  // Reset values, load of the count, refused accesses
  task automatic t_regs;
    logic [33:0] rsp;
    axi(1'b0, 12'h000, 32'h0, rsp);
    `CHK(rsp, {2'h0, 32'h0})
    axi(1'b1, 12'h004, 32'h0000_1234, rsp);
    `CHK(rsp[33:32], 2'h0)
    axi(1'b0, 12'h004, 32'h0, rsp);
    `CHK(rsp, {2'h0, 32'h0000_1234})
    axi(1'b1, 12'h008, 32'h0000_0001, rsp);
    `CHK(rsp[33:32], 2'h2)
    axi(1'b0, 12'h00C, 32'h0, rsp);
    `CHK(rsp, {2'h2, 32'h0})
  endtask

  // Bus side events and core qualifiers
  task automatic t_bus;
    perf_fe_pkg::fe_events_t d;
    logic [33:0] rsp;
    run(16'h7B00, '{mod_hit_drive:1, default:0}, 8, 2);
    d = '{queue_empty_per_core_qualifier:1, default:0};
    run(16'h7D40, d, 8, 8);
    run(16'h7DC0, d, 8, 0);
    run(16'h7D00, d, 8, 0);
    d = '{queue_empty_per_core_qualifier:1, queue_empty_other:1, default:0};
    run(16'h7DC0, d, 8, 8);
    run(16'h7D40, '{halted_per_core_qualifier:1, default:0}, 8, 8);
    run(16'h7F40, '{io_wait_other:1, default:0}, 8, 0);
    run(16'h7FC0, '{io_wait_other:1, default:0}, 8, 8);
    run(16'h7F40, '{io_wait_per_core_qualifier:1, default:0}, 8, 8);
    // Status bit 0 shows a listed pair is selected
    axi(1'b0, 12'h008, 32'h0, rsp);
    `CHK(rsp, {2'h0, 32'h0000_0001})
  endtask

  // Fetch, translation, queue and decoder events
  task automatic t_fetch;
    perf_fe_pkg::fe_events_t d;
    d = '{fetch:1, uc_fetch:1, default:0};
    run(16'h8000, d, 4, 8);
    run(16'h8001, d, 4, 0);
    run(16'h8100, '{fetch_miss_pend:1, default:0}, 5, 1);
    run(16'h8100, '{uc_fetch:1, default:0}, 3, 3);
    d = '{small_page_miss:1, large_page_miss:1, default:0};
    run(16'h8212, d, 3, 6);
    run(16'h8202, d, 3, 3);
    run(16'h8210, d, 3, 3);
    run(16'h8204, d, 3, 0);
    run(16'h8240, '{xlate_flush:1, default:0}, 3, 3);
    run(16'h8302, '{iq_full:1, default:0}, 7, 7);
    d = '{stall_cache_miss:1, stall_xlate_fault:1, default:0};
    run(16'h8600, d, 4, 4);
    run(16'h8600, '{stall_xlate_miss:1, default:0}, 4, 4);
    run(16'h8700, '{slow_decode_start:1, default:0}, 3, 6);
  endtask

  // Prompt and late snoop answers, stall from another agent
  task automatic t_snoop;
    resp_dly <= 4'h0;
    run(16'h7E00, '{snoop_req:1, default:0}, 1, 0);
    resp_dly <= 4'h5;
    run(16'h7E00, '{snoop_req:1, default:0}, 1, 1);
    run(16'h7E00, '{snoop_stall_bus:1, default:0}, 8, 1);
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    reset_n = 1'b0;
    drive = '0;
    resp_dly = 4'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_bus();
    t_fetch();
    t_snoop();
    summarize();
  end

  // Run needs about 1500 cycles; cut a hang well after that
  initial begin
    #200000;
    num_errors++;
    summarize();
  end
endmodule
